// [dll_mode_ctrl.sv]
// Command decode, DLL mode, self-refresh clock gating and write leveling.
// Assumes command pins are sampled on the device clock by the caller.
`timescale 1ns/1ps
`include "dll_mode_defs.svh"
module dll_mode_ctrl
	import dll_mode_pkg::*;
(
	// Clocking
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        clock_enable,
	// Command pins, active low strobes
	input  wire logic        cke,
	input  wire logic        chip_select_n,
	input  wire logic        row_strobe_n,
	input  wire logic        column_strobe_n,
	input  wire logic        write_enable_n,
	input  wire logic [2:0]  bank,
	input  wire logic [13:0] address,
	// Latency setup
	input  wire logic [3:0]  additive_latency,
	// Write leveling strobes and clock level, from pins
	input  wire logic        strobe_lower,
	input  wire logic        strobe_upper,
	input  wire logic        clock_level,
	// Status and results
	output logic             dll_enabled,
	output logic             leveling_active,
	output logic [3:0]       read_latency,
	output logic [3:0]       write_latency,
	output logic             latency_error,
	output logic             self_refresh,
	output logic             clock_ignored,
	output logic             read_launch,
	output logic [7:0]       feedback_lower,
	output logic [7:0]       feedback_upper,
	output logic             command_taken
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]  sync_lo;
		logic [2:0]  sync_up;
		logic [2:0]  sync_ck;
		logic        lvl_lo;
		logic        lvl_up;
		logic        dll_disable;
		logic        leveling;
		logic [3:0]  read_latency;
		logic [3:0]  write_latency;
		logic        cke_prev;
		pwr_state_t  pwr;
		logic [7:0]  hold_count;
		logic        clock_ignored;
		logic [7:0]  feedback_lower;
		logic [7:0]  feedback_upper;
		logic        taken;
	} ctrl_state_t;
	ctrl_state_t state;
	ctrl_state_t next_state;
	cmd_kind_t   kind;
	logic        read_start;
	logic [4:0]  read_tap;
	logic        launch_hit;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always_comb begin
		if (chip_select_n) begin
			kind = cmd_deselect;
		end else begin
			case ({row_strobe_n, column_strobe_n, write_enable_n})
				3'h7: kind = cmd_idle;
				3'h0: kind = cmd_mode_write;
				3'h5: kind = cmd_read;
				3'h1: kind = cmd_refresh;
				default: kind = cmd_other;
			endcase
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.taken = 1'b0;
		next_state.sync_lo = {state.sync_lo[1:0], strobe_lower};
		next_state.sync_up = {state.sync_up[1:0], strobe_upper};
		next_state.sync_ck = {state.sync_ck[1:0], clock_level};
		next_state.cke_prev = cke;
		case (state.pwr)
			pwr_active: begin
				if (state.cke_prev && cke) begin
					next_state.taken = (kind != cmd_deselect) && (kind != cmd_idle);
					if (kind == cmd_mode_write) begin
						case (bank)
							`SEL_MODE_REG_ONE: begin
								next_state.dll_disable = address[`DLL_DISABLE_POS];
								next_state.leveling = address[`LEVELING_ENABLE_POS];
							end
							`SEL_MODE_REG_ZERO: next_state.read_latency = address[7:4];
							`SEL_MODE_REG_TWO: next_state.write_latency = address[6:3];
							default: next_state.taken = 1'b1;
						endcase
					end
				end else if (state.cke_prev && !cke) begin
					if (kind == cmd_refresh) begin
						next_state.pwr = pwr_self_refresh;
						next_state.hold_count = `CLOCK_HOLD_AFTER_SR_ENTRY;
					end else begin
						next_state.pwr = pwr_power_down;
					end
				end
			end
			pwr_self_refresh: begin
				if (state.hold_count != 8'h00) begin
					next_state.hold_count = state.hold_count - 8'h01;
				end else begin
					next_state.clock_ignored = 1'b1;
				end
				if (cke) begin
					next_state.pwr = pwr_active;
					next_state.clock_ignored = 1'b0;
				end
			end
			pwr_power_down: begin
				if (cke) begin
					next_state.pwr = pwr_active;
				end
			end
			default: next_state.pwr = pwr_active;
		endcase
		// Strobe level counts once second and third stages agree, so glitches drop
		if (state.sync_lo[2] == state.sync_lo[1]) begin
			next_state.lvl_lo = state.sync_lo[2];
		end
		if (state.sync_up[2] == state.sync_up[1]) begin
			next_state.lvl_up = state.sync_up[2];
		end
		// Clock level captured on a settled strobe rise, per lane
		if (state.leveling && state.sync_lo[2:1] == 2'h3 && !state.lvl_lo) begin
			next_state.feedback_lower = {8{state.sync_ck[2]}};
		end
		if (state.leveling && state.sync_up[2:1] == 2'h3 && !state.lvl_up) begin
			next_state.feedback_upper = {8{state.sync_ck[2]}};
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= '{sync_lo: 3'h0, sync_up: 3'h0, sync_ck: 3'h0, lvl_lo: 1'b0, lvl_up: 1'b0,
				dll_disable: 1'b0, leveling: 1'b0,
				read_latency: `RESET_READ_LATENCY, write_latency: `RESET_WRITE_LATENCY,
				cke_prev: 1'b0, pwr: pwr_active, hold_count: 8'h00,
				clock_ignored: 1'b0, feedback_lower: 8'h00, feedback_upper: 8'h00,
				taken: 1'b0};
		end else if (clock_enable) begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Read launch timing
	// ----------------------------------------
	// DLL-off drops one cycle from the launch point
	always_comb begin
		read_start = (kind == cmd_read) && state.cke_prev && cke && (state.pwr == pwr_active);
		read_tap = 5'(additive_latency) + 5'(state.read_latency)
			- (state.dll_disable ? 5'h01 : 5'h00);
	end

	latency_shift #(
		.DEPTH (32)
	) u_launch (
		.clock  (clock),
		.resetn (resetn),
		.enable (clock_enable),
		.start  (read_start),
		.tap    (read_tap),
		.hit    (launch_hit)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dll_enabled = !state.dll_disable;
	assign leveling_active = state.leveling;
	assign read_latency = state.read_latency;
	assign write_latency = state.write_latency;
	// Flags a latency pair that DLL-off cannot honour
	assign latency_error = state.dll_disable
		&& (state.read_latency != `DLL_OFF_READ_LATENCY
		|| state.write_latency != `DLL_OFF_WRITE_LATENCY);
	assign self_refresh = (state.pwr == pwr_self_refresh);
	assign clock_ignored = state.clock_ignored;
	assign read_launch = launch_hit;
	assign feedback_lower = state.feedback_lower;
	assign feedback_upper = state.feedback_upper;
	assign command_taken = state.taken;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_deselect_no_cmd: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && chip_select_n |=> !command_taken)
		else $error("deselect took a command");
	a_idle_no_cmd: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && !chip_select_n && row_strobe_n && column_strobe_n && write_enable_n
		|=> !command_taken)
		else $error("idle took a command");
	a_dll_bit_write: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && state.pwr == pwr_active && state.cke_prev && cke
		&& kind == cmd_mode_write && bank == `SEL_MODE_REG_ONE
		|=> dll_enabled == !$past(address[`DLL_DISABLE_POS]))
		else $error("dll bit not taken");
	a_level_bit_write: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && state.pwr == pwr_active && state.cke_prev && cke
		&& kind == cmd_mode_write && bank == `SEL_MODE_REG_ONE
		|=> leveling_active == $past(address[`LEVELING_ENABLE_POS]))
		else $error("leveling bit not taken");
	a_latency_flag: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && state.pwr == pwr_active && state.cke_prev && cke && state.dll_disable
		&& kind == cmd_mode_write && bank == `SEL_MODE_REG_ZERO
		&& address[7:4] != `DLL_OFF_READ_LATENCY |=> latency_error)
		else $error("latency flag missing with dll off");
	a_clock_ignored: assert property (@(posedge clock) disable iff (!resetn)
		clock_ignored |-> self_refresh)
		else $error("clock ignored outside self refresh");
	a_sr_hold_time: assert property (@(posedge clock) disable iff (!resetn)
		$rose(self_refresh) |-> !clock_ignored [*5])
		else $error("clock ignored too early");
	a_zero_tap_launch: assert property (@(posedge clock) disable iff (!resetn)
		clock_enable && read_start && read_tap == 5'h00 |=> read_launch)
		else $error("zero latency launch missing");
endmodule

// [dll_mode_defs.svh]
// Constants for the DLL mode and command decode block.
// Assumes inclusion by bare name from the design files.
`ifndef DLL_MODE_DEFS_SVH
`define DLL_MODE_DEFS_SVH
// Mode register select codes on the bank address
`define SEL_MODE_REG_ZERO 3'h0
`define SEL_MODE_REG_ONE  3'h1
`define SEL_MODE_REG_TWO  3'h2
// Field positions
`define DLL_DISABLE_POS     0
`define LEVELING_ENABLE_POS 7
`define DLL_RESET_POS       8
// DLL-off latency pair
`define DLL_OFF_READ_LATENCY  4'h6
`define DLL_OFF_WRITE_LATENCY 4'h6
// Reset values
`define RESET_READ_LATENCY  4'h6
`define RESET_WRITE_LATENCY 4'h6
// Clock hold after self-refresh entry, in cycles
`define CLOCK_HOLD_AFTER_SR_ENTRY 8'h05
`endif

// [dll_mode_pkg.sv]
// Types shared by the DLL mode block.
// Assumes no surroundings beyond the compiler.
package dll_mode_pkg;
	typedef enum logic [2:0] {
		cmd_deselect,
		cmd_idle,
		cmd_mode_write,
		cmd_read,
		cmd_refresh,
		cmd_other
	} cmd_kind_t;
	typedef enum {
		pwr_active,
		pwr_self_refresh,
		pwr_power_down
	} pwr_state_t;
endpackage

// [latency_shift.sv]
// Delay line that times read data launch from a read command.
// Assumes the enclosing logic gives the tap count per cycle.
`timescale 1ns/1ps
module latency_shift #(
	parameter int DEPTH = 32
) (
	// Clocking
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             enable,
	// Request and tap
	input  wire logic             start,
	input  wire logic [4:0]       tap,
	output logic                  hit
);
	typedef struct packed {
		logic [DEPTH-1:0] line;
		logic             hit;
	} shift_state_t;
	shift_state_t state;
	shift_state_t next_state;
	always_comb begin
		next_state = state;
		next_state.line = {state.line[DEPTH-2:0], start};
		next_state.hit = (tap == 5'h00) ? start : state.line[tap - 5'h01];
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= '0;
		end else if (enable) begin
			state <= next_state;
		end
	end
	assign hit = state.hit;
endmodule

// [mem_ctrl_model.sv]
// Controller-side model: drives clock enable, command pins and strobes.
// Assumes the bench calls its tasks and shares the device clock.
`timescale 1ns/1ps
module mem_ctrl_model
	import dll_mode_pkg::*;
(
	// Clocking
	input  wire logic        clock,
	// Command pins
	output logic             cke,
	output logic             chip_select_n,
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	output logic             write_enable_n,
	output logic [2:0]       bank,
	output logic [13:0]      address,
	// Leveling pins
	output logic             strobe_lower,
	output logic             strobe_upper,
	output logic             clock_level
);
	// Deselected pins float, so each call loads them with fresh random values
	task automatic deselect(input logic ck);
		cke = ck;
		chip_select_n = 1'b1;
		{row_strobe_n, column_strobe_n, write_enable_n, bank, address} = 20'($urandom);
	endtask
	initial begin
		strobe_lower = 1'b0;
		strobe_upper = 1'b0;
		clock_level = 1'b0;
		deselect(1'b1);
	end
	// One command cycle, then deselect; waits only ever carry deselect
	task automatic send(input cmd_kind_t k, input logic [2:0] ba, input logic [13:0] a,
		input logic ck);
		@(posedge clock);
		#1;
		if (k == cmd_deselect) begin
			deselect(ck);
		end else begin
			cke = ck;
			case (k)
				cmd_mode_write: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h0;
				cmd_read:       {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h5;
				cmd_refresh:    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h1;
				default:        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
			endcase
			bank = ba;
			address = a;
		end
		@(posedge clock);
		#1;
		deselect(ck);
	endtask
	task automatic wait_idle(input int n);
		repeat (n) begin
			@(posedge clock);
			#1;
			deselect(cke);
		end
	endtask
	// Strobe delay step: clock level settles before the strobe rises
	task automatic level(input int lane, input logic lv);
		@(posedge clock);
		#1;
		clock_level = lv;
		@(posedge clock);
		#1;
		if (lane == 0) strobe_lower = 1'b1;
		else strobe_upper = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		strobe_lower = 1'b0;
		strobe_upper = 1'b0;
	endtask
endmodule

// [testbench.sv]
// Self-checking bench for the DLL mode block with a reference model.
// Assumes the controller model drives all command and strobe pins.
`timescale 1ns/1ps
`include "dll_mode_defs.svh"
module testbench
	import dll_mode_pkg::*;
;
	logic clock, resetn, clock_enable, cke, chip_select_n, row_strobe_n, column_strobe_n;
	logic write_enable_n, strobe_lower, strobe_upper, clock_level;
	logic dll_enabled, leveling_active, latency_error, self_refresh, clock_ignored;
	logic read_launch, command_taken;
	logic [2:0] bank;
	logic [13:0] address;
	logic [3:0] additive_latency, read_latency, write_latency;
	logic [7:0] feedback_lower, feedback_upper;
	int fail_count, n_checks, cycles, n;
	int m_dll, m_lev, m_rl, m_wl, m_fb[2];
	dll_mode_ctrl i_dut (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
		.cke(cke), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n), .bank(bank),
		.address(address), .additive_latency(additive_latency), .strobe_lower(strobe_lower),
		.strobe_upper(strobe_upper), .clock_level(clock_level), .dll_enabled(dll_enabled),
		.leveling_active(leveling_active), .read_latency(read_latency),
		.write_latency(write_latency), .latency_error(latency_error),
		.self_refresh(self_refresh), .clock_ignored(clock_ignored), .read_launch(read_launch),
		.feedback_lower(feedback_lower), .feedback_upper(feedback_upper),
		.command_taken(command_taken));
	mem_ctrl_model i_ctrl (.clock(clock), .cke(cke), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.write_enable_n(write_enable_n), .bank(bank), .address(address),
		.strobe_lower(strobe_lower), .strobe_upper(strobe_upper), .clock_level(clock_level));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_state();
		chk("dll_enabled", 16'(m_dll), dll_enabled);
		chk("leveling_active", 16'(m_lev), leveling_active);
		chk("read_latency", 16'(m_rl), read_latency);
		chk("write_latency", 16'(m_wl), write_latency);
		chk("latency_error", 16'(m_dll == 0 && (m_rl != 6 || m_wl != 6)), latency_error);
		chk("feedback_lower", 16'(m_fb[0]), feedback_lower);
		chk("feedback_upper", 16'(m_fb[1]), feedback_upper);
	endtask
	task automatic mw(input logic [2:0] ba, input logic [13:0] a);
		i_ctrl.send(cmd_mode_write, ba, a, 1'b1);
		chk("command_taken", 16'h0001, command_taken);
		if (ba == 3'h1) begin
			m_dll = !a[0];
			m_lev = a[7];
		end
		if (ba == 3'h0) m_rl = a[7:4];
		if (ba == 3'h2) m_wl = a[6:3];
		check_state();
	endtask
	// Launch edge counted from the edge that took the read
	task automatic rd(input int al_max);
		int al;
		al = $urandom_range(0, al_max);
		additive_latency = 4'(al);
		i_ctrl.send(cmd_read, 3'h0, 14'h0000, 1'b1);
		n = 1;
		while (read_launch !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("read_launch", 16'(al + m_rl - (m_dll ? 0 : 1) + 1), 16'(n));
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		{m_dll, m_lev, m_rl, m_wl, m_fb[0], m_fb[1]} = {32'd1, 32'd0, 32'd6, 32'd6, 64'd0};
		{fail_count, n_checks, cycles} = '0;
		resetn = 1'b0;
		clock_enable = 1'b1;
		additive_latency = 4'h0;
		void'($urandom(4899));
		repeat (5) @(posedge clock);
		#1;
		resetn = 1'b1;
		i_ctrl.wait_idle(2);
		check_state();
		// ----------------------------------------
		// Idle and deselect take nothing
		// ----------------------------------------
		for (int k = 0; k < 2; k++) begin
			i_ctrl.send(k ? cmd_idle : cmd_deselect, 3'h1, 14'h0001, 1'b1);
			chk("command_taken", 16'h0000, command_taken);
			check_state();
		end
		// ----------------------------------------
		// Clock enable low freezes all state
		// ----------------------------------------
		clock_enable = 1'b0;
		i_ctrl.send(cmd_mode_write, 3'h1, 14'h0081, 1'b1);
		chk("command_taken", 16'h0000, command_taken);
		check_state();
		clock_enable = 1'b1;
		rd(4);
		mw(3'h1, 14'h0001);
		i_ctrl.wait_idle(4);
		mw(3'h0, 14'h0070);
		mw(3'h0, 14'h0060);
		rd(4);
		// ----------------------------------------
		// Self-refresh with the clock dropped
		// ----------------------------------------
		i_ctrl.send(cmd_refresh, 3'h0, 14'h0000, 1'b0);
		chk("self_refresh", 16'h0001, self_refresh);
		n = 1;
		while (clock_ignored !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("clock_ignored_delay", 16'(`CLOCK_HOLD_AFTER_SR_ENTRY + 2), 16'(n));
		i_ctrl.send(cmd_mode_write, 3'h1, 14'h0000, 1'b0);
		chk("command_taken", 16'h0000, command_taken);
		check_state();
		i_ctrl.send(cmd_deselect, 3'h0, 14'h0000, 1'b1);
		i_ctrl.wait_idle(1);
		chk("self_refresh", 16'h0000, self_refresh);
		i_ctrl.wait_idle(2);
		mw(3'h1, 14'h0000);
		mw(3'h0, 14'h0160);
		i_ctrl.wait_idle(4);
		rd(4);
		// Random mode writes, unknown select included
		repeat (8) mw(3'($urandom_range(0, 3)), 14'($urandom));
		mw(3'h1, 14'h0000);
		mw(3'h0, 14'h0060);
		mw(3'h2, 14'h0030);
		// Zero total latency launches on the very next edge
		mw(3'h0, 14'h0000);
		rd(0);
		mw(3'h0, 14'h0060);
		// ----------------------------------------
		// Write leveling per byte lane
		// ----------------------------------------
		mw(3'h1, 14'h0080);
		for (int lane = 0; lane < 2; lane++) begin
			for (int lv = 0; lv < 2; lv++) begin
				i_ctrl.level(lane, 1'(lv));
				i_ctrl.wait_idle(4);
				m_fb[lane] = lv ? 8'hFF : 8'h00;
				check_state();
			end
		end
		// ----------------------------------------
		// Reset in mid-run, leveling in progress
		// ----------------------------------------
		resetn = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		resetn = 1'b1;
		{m_dll, m_lev, m_rl, m_wl, m_fb[0], m_fb[1]} = {32'd1, 32'd0, 32'd6, 32'd6, 64'd0};
		i_ctrl.wait_idle(2);
		check_state();
		// ----------------------------------------
		// Precharge power-down with a mode write attempted
		// ----------------------------------------
		i_ctrl.send(cmd_deselect, 3'h0, 14'h0000, 1'b0);
		i_ctrl.send(cmd_mode_write, 3'h1, 14'h0001, 1'b0);
		chk("command_taken", 16'h0000, command_taken);
		chk("self_refresh", 16'h0000, self_refresh);
		check_state();
		i_ctrl.send(cmd_deselect, 3'h0, 14'h0000, 1'b1);
		i_ctrl.wait_idle(2);
		mw(3'h0, 14'h0160);
		rd(4);
		mw(3'h1, 14'h0000);
		end_of_test();
	end
endmodule
